// [src/vca_pkg.sv]
// shared constants, opcodes and carriers for the vector add/compare/clip alu
package vca_pkg;
	localparam int NUM_SLICES = 8; // vector slices
	localparam int HW_W = 16; // halfword element width
	localparam int ACC_W = 48; // halfword accumulator width
	localparam int ACC_ALIGN = 16; // partial results land at acc[31:16]
	localparam int BYTE_ACC_W = 18; // byte accumulator width
	localparam int BYTE_LO_POS = 0; // low byte lane position in acc
	localparam int BYTE_HI_POS = 18; // high byte lane position in acc
	localparam logic [15:0] HW_MAX = 16'h7FFF; // +32767
	localparam logic [15:0] HW_MIN = 16'h8000; // -32768
	localparam logic [7:0] BYTE_MAX = 8'hFF; // 255
	localparam logic [15:0] CARRY_EQUAL_RESET = 16'h0000;
	localparam logic [15:0] COMPARE_RESET = 16'h0000;
	localparam logic [7:0] CLIP_EXT_RESET = 8'h00;
	localparam logic [47:0] ACC_RESET = 48'h000000000000;
	// control word selectors for the move-control port
	localparam logic [1:0] SEL_COMPARE = 2'h0;
	localparam logic [1:0] SEL_CARRY_EQUAL = 2'h1;
	localparam logic [1:0] SEL_CLIP_EXT = 2'h2;

	// operations of this datapath
	typedef enum logic [4:0] {
		OP_NONE,
		OP_ADD_WITH_CARRY_OUT,
		OP_SUB_WITH_BORROW_OUT,
		OP_HALFWORD_ADD,
		OP_HALFWORD_ADD_ACCUMULATE,
		OP_HALFWORD_SUBTRACT,
		OP_HALFWORD_SUB_ACCUMULATE,
		OP_REVERSE_SUBTRACT,
		OP_CONDITIONAL_NEGATE,
		OP_COMPARE_LESS,
		OP_COMPARE_GREATER_EQUAL,
		OP_COMPARE_EQUAL,
		OP_COMPARE_NOT_EQUAL,
		OP_FLAG_MERGE_SELECT,
		OP_CLIP_LOW_TWOS,
		OP_CLIP_ONES_COMPLEMENT,
		OP_CLIP_HIGH_HALF,
		OP_BYTE_ADD,
		OP_BYTE_SUBTRACT,
		OP_BYTE_MULTIPLY_LOAD,
		OP_BYTE_MULTIPLY_LOAD_NEGATED
	} vca_op_t;

	// byte lane operation kinds
	typedef enum logic [1:0] {
		BOP_ADD,
		BOP_SUB,
		BOP_MUL,
		BOP_MULN
	} vca_bop_t;

	// one issued instruction
	typedef struct packed {
		vca_op_t op;
		logic dbl; // second half of a double-precision compare/clip
		logic [3:0] elem;
		logic [127:0] first_source_reg;
		logic [127:0] second_source_reg;
	} vca_issue_t;

	// move-control access from the scalar core
	typedef struct packed {
		logic wr;
		logic [1:0] sel;
		logic [15:0] wdata;
	} vca_ctl_t;
endpackage

// [src/vca_byte_lane.sv]
// one unsigned byte lane: 18-bit accumulator load, shift and clamp
`timescale 1ns/1ns
module vca_byte_lane
	import vca_pkg::*;
(
	input wire vca_bop_t bop,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic [2:0] shift,
	output logic [BYTE_ACC_W-1:0] acc_o,
	output logic [7:0] res_o
);
	logic [BYTE_ACC_W-1:0] rnd; // rounding increment
	logic [BYTE_ACC_W-1:0] shifted; // accumulator after scaling

	// operands are unsigned 0..255; full 18-bit load sets bits 17:16
	always_comb begin
		rnd = '0;
		if (shift != 3'h0) begin
			rnd = BYTE_ACC_W'(1) << (shift - 3'h1); // see (RQ22)
		end
		case (bop)
			BOP_ADD: acc_o = {10'h000, a} + {10'h000, b} + rnd; // see (RQ20)
			BOP_SUB: acc_o = {10'h000, a} - {10'h000, b} + rnd;
			// widen first: a bare product inside braces keeps only 8 bits
			BOP_MUL: acc_o = {2'h0, 16'(a) * 16'(b)};
			BOP_MULN: acc_o = 18'h00000 - {2'h0, 16'(a) * 16'(b)};
			default: acc_o = '0;
		endcase
	end

	// arithmetic shift lets bits 17:16 into the byte, then clamp to 0..255
	always_comb begin
		shifted = $signed(acc_o) >>> shift; // see (RQ21)
		if (shifted[BYTE_ACC_W-1]) begin
			res_o = 8'h00; // see (RQ22)
		end else if (|shifted[BYTE_ACC_W-2:8]) begin
			res_o = BYTE_MAX;
		end else begin
			res_o = shifted[7:0];
		end
	end
endmodule

// [src/vca_alu.sv]
// eight-slice halfword/byte add, compare and clip datapath with flag regs
`timescale 1ns/1ns
// What this block does
// (RQ1) carry/equal: ne bits high, carry low
// (RQ2) carry-out add/sub set ne and carry
// (RQ3) plain add/sub use carry, clear carry/equal
// (RQ4) compare writes low byte, clears high
// (RQ5) compare bit set when comparison true
// (RQ6) merge selects by compare bits only
// (RQ7) double compare also uses carry/equal
// (RQ8) every compare clears carry/equal
// (RQ9) twos/ones clips set compare flags from result
// (RQ10) clip: high outside, low direction
// (RQ11) high clip sets carry/equal sign bits
// (RQ12) high clip writes clip-extension bits
// (RQ13) double clip uses both flag regs
// (RQ14) single clips clear carry/equal, extension
// (RQ15) vd saturated, accumulator unsaturated
// (RQ16) partial aligned to accumulator 31:16
// (RQ17) load or accumulate, then write vd
// (RQ18) reverse subtract: element minus source
// (RQ19) negate by sign of first source
// (RQ20) bytes unsigned, acc EX2, vd writeback
// (RQ21) byte element low bits give shift
// (RQ22) 18-bit byte acc, round, clamp 0..255
// (RQ23) element field selects broadcast element
// (RQ24) byte and halfword accumulators shared
// (RQ25) flag registers clear on reset
module vca_alu
	import vca_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic issue_valid,
	input wire vca_issue_t issue,
	input wire vca_ctl_t ctl,
	output logic wb_valid_q,
	output logic [127:0] destination_reg_q,
	output logic [15:0] ctl_rdata_q,
	output logic [15:0] carry_equal_flags_q,
	output logic [15:0] compare_flags_q,
	output logic [7:0] clip_extension_flags_q
);
	// execute_stage_one: instruction with broadcast operand applied
	logic ex1_valid_q, ex1_dbl_q;
	vca_op_t ex1_op_q;
	logic [3:0] ex1_elem_q;
	logic [127:0] ex1_s_q, ex1_t_q; // first source, selected second source
	// execute_stage_two state
	logic [47:0] acc_q [NUM_SLICES]; // shared halfword/byte storage
	logic [47:0] acc_d [NUM_SLICES];
	logic [15:0] res_d [NUM_SLICES]; // value bound for writeback
	logic [15:0] vco_new, vcc_new; // carry/equal and compare next values
	logic [7:0] vce_new; // clip-extension next value
	logic vco_we, vcc_we, vce_we; // which flag regs the op writes
	logic acc_we; // op writes the accumulator
	logic is_byte; // op is a byte-lane op
	vca_bop_t bop;

	// pick the second-source element for slice i from the element field
	function automatic logic [2:0] pick(input logic [3:0] e,
		input logic [2:0] i);
		// 1xxx one of eight, 01xx one per half, 001x one per quarter
		return e[3] ? e[2:0] : e[2] ? {i[2], e[1:0]} :
			e[1] ? {i[2:1], e[0]} : i;
	endfunction

	// saturate accumulator bits 47:16 to a signed halfword
	function automatic logic [15:0] sat16(input logic [47:0] a);
		return (a[47:31] == {17{a[47]}}) ? a[31:16] :
			(a[47] ? HW_MIN : HW_MAX);
	endfunction

	// stage one register; broadcast is resolved here
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ex1_valid_q <= 1'b0;
			ex1_op_q <= OP_NONE;
			ex1_dbl_q <= 1'b0;
			ex1_elem_q <= 4'h0;
			ex1_s_q <= '0;
			ex1_t_q <= '0;
		end else begin
			ex1_valid_q <= issue_valid;
			ex1_op_q <= issue_valid ? issue.op : OP_NONE;
			ex1_dbl_q <= issue.dbl;
			ex1_elem_q <= issue.elem;
			ex1_s_q <= issue.first_source_reg;
			for (int i = 0; i < NUM_SLICES; i++) begin
				// byte add/sub keep top element bit 0, so no one-of-eight broadcast
				ex1_t_q[i*16 +: 16] <= issue.second_source_reg[
					pick(issue.elem, 3'(i))*16 +: 16]; // see (RQ23)
			end
		end
	end

	// per-op decode of which state gets written in stage two
	always_comb begin
		vco_we = 1'b0;
		vcc_we = 1'b0;
		vce_we = 1'b0;
		acc_we = 1'b0;
		is_byte = 1'b0;
		case (ex1_op_q)
			OP_ADD_WITH_CARRY_OUT, OP_SUB_WITH_BORROW_OUT,
			OP_HALFWORD_ADD, OP_HALFWORD_ADD_ACCUMULATE,
			OP_HALFWORD_SUBTRACT, OP_HALFWORD_SUB_ACCUMULATE,
			OP_REVERSE_SUBTRACT: begin
				vco_we = 1'b1; // see (RQ2) (RQ3)
				acc_we = 1'b1;
			end
			OP_CONDITIONAL_NEGATE: acc_we = 1'b1;
			OP_COMPARE_LESS, OP_COMPARE_GREATER_EQUAL,
			OP_COMPARE_EQUAL, OP_COMPARE_NOT_EQUAL: begin
				vco_we = 1'b1; // see (RQ8)
				vcc_we = 1'b1;
			end
			OP_CLIP_LOW_TWOS, OP_CLIP_ONES_COMPLEMENT: begin
				vco_we = 1'b1; // see (RQ14)
				vcc_we = 1'b1;
				vce_we = 1'b1;
			end
			OP_CLIP_HIGH_HALF: begin
				vco_we = 1'b1; // see (RQ11)
				vce_we = 1'b1;
			end
			OP_BYTE_ADD, OP_BYTE_SUBTRACT, OP_BYTE_MULTIPLY_LOAD,
			OP_BYTE_MULTIPLY_LOAD_NEGATED: begin
				acc_we = 1'b1;
				is_byte = 1'b1;
			end
			default: ; // merge and idle touch no state
		endcase
	end

	// byte lane kind follows the opcode; other ops ignore the lanes
	always_comb begin
		case (ex1_op_q)
			OP_BYTE_SUBTRACT: bop = BOP_SUB;
			OP_BYTE_MULTIPLY_LOAD: bop = BOP_MUL;
			OP_BYTE_MULTIPLY_LOAD_NEGATED: bop = BOP_MULN;
			default: bop = BOP_ADD;
		endcase
	end

	// stage two, one copy per slice
	for (genvar i = 0; i < NUM_SLICES; i++) begin : g_slice
		logic [15:0] s, t; // first source, selected second source
		logic [16:0] sx, tx; // sign-extended s and t
		logic [16:0] part, u, c; // partial, carry sum, clip comparison
		logic [47:0] part48; // partial aligned to 31:16
		logic cin; // carry/borrow from previous op
		logic ne_i, cy_i, hi_i, lo_i, ce_i; // this slice's flag bits
		logic sgn, outside; // operand signs differ; clip triggered
		logic [17:0] bacc_hi, bacc_lo; // byte lane accumulator words
		logic [7:0] bres_hi, bres_lo; // byte lane results
		assign s = ex1_s_q[i*16 +: 16];
		assign t = ex1_t_q[i*16 +: 16];
		assign sx = {s[15], s};
		assign tx = {t[15], t};
		assign cin = carry_equal_flags_q[7-i]; // see (RQ1)
		// two byte lanes in the shared accumulator word
		vca_byte_lane u_hi (
			.bop(bop),
			.a(s[15:8]),
			.b(t[15:8]),
			.shift(ex1_elem_q[2:0]),
			.acc_o(bacc_hi),
			.res_o(bres_hi)
		);
		vca_byte_lane u_lo (
			.bop(bop),
			.a(s[7:0]),
			.b(t[7:0]),
			.shift(ex1_elem_q[2:0]),
			.acc_o(bacc_lo),
			.res_o(bres_lo)
		);
		// arithmetic, compare and clip for this slice
		always_comb begin
			u = {1'b0, s} + {1'b0, t};
			c = '0;
			part = '0;
			ne_i = 1'b0;
			cy_i = 1'b0;
			hi_i = 1'b0;
			lo_i = 1'b0;
			ce_i = 1'b0;
			sgn = s[15] ^ t[15];
			outside = 1'b0;
			res_d[i] = s;
			case (ex1_op_q)
				OP_ADD_WITH_CARRY_OUT: begin
					part = sx + tx;
					cy_i = u[16]; // see (RQ2)
					ne_i = |u[15:0];
				end
				OP_SUB_WITH_BORROW_OUT: begin
					u = {1'b0, s} - {1'b0, t};
					part = sx - tx;
					cy_i = u[16]; // see (RQ2)
					ne_i = (s != t);
				end
				OP_HALFWORD_ADD, OP_HALFWORD_ADD_ACCUMULATE:
					part = sx + tx + {16'h0000, cin}; // see (RQ3)
				OP_HALFWORD_SUBTRACT, OP_HALFWORD_SUB_ACCUMULATE:
					part = sx - tx - {16'h0000, cin}; // see (RQ3)
				OP_REVERSE_SUBTRACT:
					part = tx - sx - {16'h0000, cin}; // see (RQ18)
				OP_CONDITIONAL_NEGATE:
					part = s[15] ? 17'h00000 - tx : tx; // see (RQ19)
				OP_COMPARE_LESS, OP_COMPARE_GREATER_EQUAL,
				OP_COMPARE_EQUAL, OP_COMPARE_NOT_EQUAL: begin
					if (ex1_dbl_q) begin
						// upper halves decided unless they were equal
						lo_i = carry_equal_flags_q[15-i] ?
							carry_equal_flags_q[7-i] : (s < t); // see (RQ7)
						hi_i = carry_equal_flags_q[15-i] | (s != t);
					end else begin
						lo_i = $signed(s) < $signed(t);
						hi_i = (s != t);
					end
					// lo_i is less-than, hi_i is not-equal here
					case (ex1_op_q)
						OP_COMPARE_LESS: ce_i = lo_i; // see (RQ5)
						OP_COMPARE_GREATER_EQUAL: ce_i = !lo_i;
						OP_COMPARE_EQUAL: ce_i = !hi_i;
						default: ce_i = hi_i;
					endcase
					lo_i = ce_i; // see (RQ4)
					hi_i = 1'b0;
					ce_i = 1'b0;
				end
				OP_FLAG_MERGE_SELECT:
					res_d[i] = compare_flags_q[7-i] ? s : t; // see (RQ6)
				OP_CLIP_LOW_TWOS, OP_CLIP_ONES_COMPLEMENT: begin
					if (ex1_dbl_q) begin
						outside = carry_equal_flags_q[15-i] |
							clip_extension_flags_q[7-i]; // see (RQ13)
						lo_i = carry_equal_flags_q[7-i];
					end else begin
						lo_i = s[15]; // see (RQ10)
						if (ex1_op_q == OP_CLIP_LOW_TWOS) begin
							outside = $signed(sx) > $signed(tx) ||
								$signed(sx) < -$signed(tx); // see (RQ9)
						end else begin
							outside = $signed(sx) > $signed(tx) ||
								$signed(sx) < $signed(~tx);
						end
					end
					hi_i = outside; // see (RQ10)
					if (outside) begin
						if (!lo_i) begin
							res_d[i] = t;
						end else if (ex1_op_q == OP_CLIP_LOW_TWOS) begin
							res_d[i] = 16'h0000 - t;
						end else begin
							res_d[i] = ~t;
						end
					end
				end
				OP_CLIP_HIGH_HALF: begin
					c = sgn ? sx + tx : sx - tx;
					outside = sgn ? c[16] : (c != 17'h00000 && !c[16]);
					ne_i = outside;
					cy_i = sgn; // see (RQ11)
					ce_i = sgn && (c == 17'h1FFFF); // see (RQ12)
					if (outside) begin
						res_d[i] = sgn ? 16'h0000 - t : t;
					end
				end
				default: ; // byte ops and idle handled below
			endcase
			part48 = {{15{part[16]}}, part, 16'h0000}; // see (RQ16)
			if (is_byte) begin
				// byte lanes overwrite bits 35:0 of the shared word, 47:36 kept; see (RQ24)
				acc_d[i] = {acc_q[i][47:36], bacc_hi, bacc_lo};
				res_d[i] = {bres_hi, bres_lo}; // see (RQ20)
			end else if (!acc_we) begin
				acc_d[i] = acc_q[i];
			end else if (ex1_op_q == OP_HALFWORD_ADD_ACCUMULATE ||
				ex1_op_q == OP_HALFWORD_SUB_ACCUMULATE) begin
				acc_d[i] = acc_q[i] + part48; // see (RQ17)
			end else begin
				acc_d[i] = part48; // see (RQ17)
			end
			if (acc_we && !is_byte) begin
				res_d[i] = sat16(acc_d[i]); // see (RQ15)
			end
		end
		// flag bit placement: slice 0 at 15 and 7, slice 7 at 8 and 0
		assign vco_new[15-i] = ne_i; // see (RQ1)
		assign vco_new[7-i] = cy_i;
		assign vcc_new[15-i] = hi_i;
		assign vcc_new[7-i] = lo_i;
		assign vce_new[7-i] = ce_i;
	end

	// accumulators written at the end of stage two
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_q <= '{default: ACC_RESET};
		end else begin
			acc_q <= acc_d; // see (RQ20)
		end
	end

	// flags: datapath update wins over a same-cycle control move
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			carry_equal_flags_q <= CARRY_EQUAL_RESET; // see (RQ25)
			compare_flags_q <= COMPARE_RESET;
			clip_extension_flags_q <= CLIP_EXT_RESET;
		end else begin
			if (vco_we) begin
				carry_equal_flags_q <= vco_new; // see (RQ3) (RQ8)
			end else if (ctl.wr && ctl.sel == SEL_CARRY_EQUAL) begin
				carry_equal_flags_q <= ctl.wdata;
			end
			if (vcc_we) begin
				compare_flags_q <= vcc_new; // see (RQ4) (RQ9)
			end else if (ctl.wr && ctl.sel == SEL_COMPARE) begin
				compare_flags_q <= ctl.wdata;
			end
			if (vce_we) begin
				clip_extension_flags_q <= vce_new; // see (RQ14)
			end else if (ctl.wr && ctl.sel == SEL_CLIP_EXT) begin
				clip_extension_flags_q <= ctl.wdata[7:0];
			end
		end
	end

	// writeback register toward the vector register file
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_valid_q <= 1'b0;
			destination_reg_q <= '0;
		end else begin
			wb_valid_q <= ex1_valid_q && ex1_op_q != OP_NONE;
			for (int i = 0; i < NUM_SLICES; i++) begin
				destination_reg_q[i*16 +: 16] <= res_d[i];
			end
		end
	end

	// registered control read; shows flags as they stand this cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_rdata_q <= 16'h0000;
		end else begin
			case (ctl.sel)
				SEL_COMPARE: ctl_rdata_q <= compare_flags_q;
				SEL_CARRY_EQUAL: ctl_rdata_q <= carry_equal_flags_q;
				SEL_CLIP_EXT: ctl_rdata_q <= {8'h00, clip_extension_flags_q};
				default: ctl_rdata_q <= 16'h0000;
			endcase
		end
	end
endmodule

// [sim/vca_alu_props.sv]
// port checker for the add/compare/clip alu
`timescale 1ns/1ns
module vca_alu_props
	import vca_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic issue_valid,
	input wire vca_issue_t issue,
	input wire vca_ctl_t ctl,
	input wire logic wb_valid_q,
	input wire logic [127:0] destination_reg_q,
	input wire logic [15:0] ctl_rdata_q,
	input wire logic [15:0] carry_equal_flags_q,
	input wire logic [15:0] compare_flags_q,
	input wire logic [7:0] clip_extension_flags_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic plain_op; // carry-consuming halfword ops
	logic cmp_op; // the four compares
	logic sclip_op; // single clips, or second half of a double clip
	logic mrg_op; // merge select
	logic hclip_op; // high-half clip
	assign plain_op = issue_valid && issue.op inside {OP_HALFWORD_ADD,
		OP_HALFWORD_ADD_ACCUMULATE, OP_HALFWORD_SUBTRACT,
		OP_HALFWORD_SUB_ACCUMULATE, OP_REVERSE_SUBTRACT};
	assign cmp_op = issue_valid && issue.op inside {OP_COMPARE_LESS,
		OP_COMPARE_GREATER_EQUAL, OP_COMPARE_EQUAL, OP_COMPARE_NOT_EQUAL};
	assign sclip_op = issue_valid
		&& issue.op inside {OP_CLIP_LOW_TWOS, OP_CLIP_ONES_COMPLEMENT};
	assign mrg_op = issue_valid && issue.op == OP_FLAG_MERGE_SELECT;
	assign hclip_op = issue_valid && issue.op == OP_CLIP_HIGH_HALF;
	// result lands two sampling edges after the issue edge
	wb_lat_a: assert property (issue_valid |-> ##2 wb_valid_q)
		else $error("writeback late or missing");
	wb_cause_a: assert property (wb_valid_q |-> $past(issue_valid, 2))
		else $error("writeback without issue");
	plain_clr_a: assert property (
		plain_op |-> ##2 carry_equal_flags_q == 16'h0000)
		else $error("carry flags kept after plain add");
	cmp_clr_a: assert property (
		cmp_op |-> ##2 (carry_equal_flags_q == 16'h0000
		&& compare_flags_q[15:8] == 8'h00))
		else $error("compare left flags set");
	// the merge leaves stage two one edge after issue; no move that edge
	mrg_keep_a: assert property (
		mrg_op ##1 !ctl.wr |=> $stable(compare_flags_q))
		else $error("merge changed compare flags");
	clip_clr_a: assert property (
		sclip_op |-> ##2 (carry_equal_flags_q == 16'h0000
		&& clip_extension_flags_q == 8'h00))
		else $error("clip left carry or extension set");
	ext_sign_a: assert property (
		hclip_op |-> ##2
		(clip_extension_flags_q & ~carry_equal_flags_q[7:0]) == 8'h00)
		else $error("extension bit without sign bit");
	rd_cmp_a: assert property (
		ctl.sel == SEL_COMPARE |=> ctl_rdata_q == $past(compare_flags_q))
		else $error("compare readback wrong");
	rd_none_a: assert property (ctl.sel == 2'h3 |=> ctl_rdata_q == 16'h0000)
		else $error("unmapped readback not zero");
	cv_cmp: cover property (cmp_op ##2 compare_flags_q != 16'h0000);
	cv_clip: cover property (sclip_op ##2 compare_flags_q[15:8] != 8'h00);
	cv_hclip: cover property (hclip_op ##2 clip_extension_flags_q != 8'h00);
endmodule

// [sim/vca_core_model.sv]
// scalar core model: issues instructions, moves flag words
`timescale 1ns/1ns
module vca_core_model
	import vca_pkg::*;
(
	input wire logic core_clk,
	output logic issue_valid,
	output vca_issue_t issue,
	output vca_ctl_t ctl
);
	// quiet at time zero
	initial begin
		issue_valid = 1'b0;
		issue = '0;
		ctl = '0;
	end
	// one instruction: valid for exactly one edge
	task automatic send(input vca_op_t op, input logic d, input logic [3:0] e,
		input logic [127:0] s, input logic [127:0] t);
		@(posedge core_clk);
		issue_valid <= 1'b1;
		issue.op <= op;
		issue.dbl <= d;
		// byte add/sub keep the element top bit clear
		issue.elem <= (op inside {OP_BYTE_ADD, OP_BYTE_SUBTRACT}) ? {1'b0, e[2:0]} : e;
		issue.first_source_reg <= s;
		issue.second_source_reg <= t;
		@(posedge core_clk);
		issue_valid <= 1'b0;
		// released operands show junk, so stale values cannot pass
		issue.first_source_reg <= ~s;
		issue.second_source_reg <= ~t;
	endtask
	// move-control word; sel stays so readback follows
	task automatic wctl(input logic w, input logic [1:0] sel, input logic [15:0] d);
		@(posedge core_clk);
		ctl <= {w, sel, d};
		@(posedge core_clk);
		ctl.wr <= 1'b0;
	endtask
endmodule

// [sim/test_vca_alu.sv]
// self-checking bench for the add/compare/clip alu
`timescale 1ns/1ns
module test_vca_alu;
	import vca_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic issue_valid;
	vca_issue_t issue;
	vca_ctl_t ctl;
	logic wb_valid_q;
	logic [127:0] destination_reg_q;
	logic [15:0] ctl_rdata_q;
	logic [15:0] carry_equal_flags_q;
	logic [15:0] compare_flags_q;
	logic [7:0] clip_extension_flags_q;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	logic [127:0] ramp; // slice i holds i
	logic [127:0] mexp;
	vca_op_t cops [4] = '{OP_COMPARE_LESS, OP_COMPARE_GREATER_EQUAL,
		OP_COMPARE_EQUAL, OP_COMPARE_NOT_EQUAL};
	logic [7:0] cexp [4] = '{8'hE0, 8'h1F, 8'h10, 8'hEF};
	always #50 core_clk = ~core_clk;
	vca_core_model i_vca_core_model (.core_clk(core_clk),
		.issue_valid(issue_valid), .issue(issue), .ctl(ctl));
	vca_alu i_vca_alu (.core_clk(core_clk), .arst_n(arst_n),
		.issue_valid(issue_valid), .issue(issue), .ctl(ctl),
		.wb_valid_q(wb_valid_q), .destination_reg_q(destination_reg_q),
		.ctl_rdata_q(ctl_rdata_q), .carry_equal_flags_q(carry_equal_flags_q),
		.compare_flags_q(compare_flags_q),
		.clip_extension_flags_q(clip_extension_flags_q));
	task automatic chk(input string nm, input logic [127:0] seen,
		input logic [127:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [127:0] rep(input logic [15:0] v);
		return {8{v}};
	endfunction
	// issue, then wait for writeback under a bound
	task automatic run(input vca_op_t op, input logic d, input logic [3:0] e,
		input logic [127:0] s, input logic [127:0] t);
		int n;
		i_vca_core_model.send(op, d, e, s, t);
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (wb_valid_q !== 1'b1 && n < 8);
		chk("wb_valid", wb_valid_q, 1'b1);
	endtask
	task automatic flags(input logic [15:0] ce, input logic [15:0] cm,
		input logic [7:0] cx);
		chk("carry_equal", carry_equal_flags_q, ce);
		chk("compare", compare_flags_q, cm);
		chk("clip_ext", clip_extension_flags_q, cx);
	endtask
	task automatic rd(input logic [1:0] sel, input logic [15:0] exp);
		i_vca_core_model.wctl(1'b0, sel, 16'h0000);
		@(negedge core_clk);
		chk("ctl_rdata", ctl_rdata_q, exp);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// hang guard, far above the hundred or so cycles used
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		for (int i = 0; i < 8; i++) ramp[i*16+:16] = 16'(i);
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		@(negedge core_clk);
		flags(16'h0000, 16'h0000, 8'h00);
		run(OP_HALFWORD_ADD, 0, 0, rep(16'h7FFF), rep(16'h0001));
		chk("sat_add", destination_reg_q, rep(16'h7FFF));
		run(OP_ADD_WITH_CARRY_OUT, 0, 0, rep(16'hFFFF), rep(16'h0001));
		chk("addc_flags", carry_equal_flags_q, 16'h00FF);
		run(OP_HALFWORD_ADD, 0, 0, rep(16'h0001), rep(16'h0001));
		chk("carry_in", destination_reg_q, rep(16'h0003));
		chk("carry_clr", carry_equal_flags_q, 16'h0000);
		run(OP_HALFWORD_ADD_ACCUMULATE, 0, 0, rep(16'h0002), rep(16'h0002));
		chk("acc_add", destination_reg_q, rep(16'h0007));
		// unsaturated accumulator survives an overflowing load
		run(OP_HALFWORD_ADD, 0, 0, rep(16'h7FFF), rep(16'h7FFF));
		run(OP_HALFWORD_SUB_ACCUMULATE, 0, 0, rep(16'hC000), rep(16'h7FFF));
		chk("acc_growth", destination_reg_q, rep(16'h3FFF));
		run(OP_REVERSE_SUBTRACT, 0, 0, rep(16'h0005), rep(16'h0002));
		chk("rev_sub", destination_reg_q, rep(16'hFFFD));
		run(OP_HALFWORD_SUBTRACT, 0, 4'hF, rep(16'h0020), {16'h0010, 112'h0});
		chk("broadcast", destination_reg_q, rep(16'h0010));
		run(OP_CONDITIONAL_NEGATE, 0, 0, rep(16'h8000), rep(16'h0005));
		chk("negate", destination_reg_q, rep(16'hFFFB));
		i_vca_core_model.wctl(1'b1, SEL_CARRY_EQUAL, 16'h00F0);
		for (int k = 0; k < 4; k++) begin
			run(cops[k], 0, 0, ramp, rep(16'h0003));
			flags(16'h0000, {8'h00, cexp[k]}, 8'h00);
		end
		mexp = ramp;
		mexp[48+:16] = 16'h00AA;
		run(OP_FLAG_MERGE_SELECT, 0, 0, ramp, rep(16'h00AA));
		chk("merge", destination_reg_q, mexp);
		chk("merge_keep", compare_flags_q, 16'h00EF);
		// upper halves first, then the low compare
		run(OP_SUB_WITH_BORROW_OUT, 0, 0, rep(16'h0001), rep(16'h0002));
		chk("subc_flags", carry_equal_flags_q, 16'hFFFF);
		run(OP_COMPARE_LESS, 1, 0, rep(16'h0005), rep(16'h0004));
		flags(16'h0000, 16'h00FF, 8'h00);
		i_vca_core_model.wctl(1'b1, SEL_CLIP_EXT, 16'h00FF);
		rd(SEL_CLIP_EXT, 16'h00FF);
		i_vca_core_model.wctl(1'b1, SEL_CARRY_EQUAL, 16'h1234);
		run(OP_CLIP_LOW_TWOS, 0, 0, rep(16'h0064), rep(16'h000A));
		chk("clip_twos", destination_reg_q, rep(16'h000A));
		flags(16'h0000, 16'hFF00, 8'h00);
		run(OP_CLIP_ONES_COMPLEMENT, 0, 0, rep(16'hFF9C), rep(16'h000A));
		chk("clip_ones", destination_reg_q, rep(16'hFFF5));
		flags(16'h0000, 16'hFFFF, 8'h00);
		run(OP_CLIP_HIGH_HALF, 0, 0, rep(16'h000F), rep(16'hFFF0));
		flags(16'hFFFF, 16'hFFFF, 8'hFF);
		i_vca_core_model.wctl(1'b1, SEL_COMPARE, 16'h0000);
		run(OP_CLIP_LOW_TWOS, 1, 0, rep(16'h0000), rep(16'h0000));
		flags(16'h0000, 16'hFFFF, 8'h00);
		rd(SEL_COMPARE, 16'hFFFF);
		rd(2'h3, 16'h0000);
		run(OP_BYTE_ADD, 0, 4'h9, rep(16'h80FF), rep(16'h9002));
		chk("byte_round", destination_reg_q, rep(16'h8881));
		run(OP_BYTE_ADD, 0, 0, rep(16'h80FF), rep(16'h9002));
		chk("byte_clamp", destination_reg_q, rep(16'hFFFF));
		run(OP_BYTE_SUBTRACT, 0, 0, rep(16'h1050), rep(16'h2010));
		chk("byte_sub", destination_reg_q, rep(16'h0040));
		// halfword accumulate sees the word the byte lanes left behind
		run(OP_HALFWORD_ADD_ACCUMULATE, 0, 0, '0, '0);
		chk("acc_shared", destination_reg_q, rep(16'hFFC0));
		run(OP_BYTE_MULTIPLY_LOAD, 0, 0, rep(16'h1003), rep(16'h1005));
		chk("byte_mul", destination_reg_q, rep(16'hFF0F));
		run(OP_BYTE_MULTIPLY_LOAD_NEGATED, 0, 0, rep(16'h0102),
			rep(16'h0101));
		chk("byte_muln", destination_reg_q, rep(16'h0000));
		close_out();
	end
endmodule
bind vca_alu vca_alu_props i_vca_alu_props (.core_clk(core_clk),
	.arst_n(arst_n), .issue_valid(issue_valid), .issue(issue), .ctl(ctl),
	.wb_valid_q(wb_valid_q), .destination_reg_q(destination_reg_q),
	.ctl_rdata_q(ctl_rdata_q), .carry_equal_flags_q(carry_equal_flags_q),
	.compare_flags_q(compare_flags_q),
	.clip_extension_flags_q(clip_extension_flags_q));
